// file: common/search_pkg.sv
/*
 * Constants, register map, field layout, defaults and state codes of the
 * coasting-motor speed search sequencer.
 * Assumes a 125 MHz system clock and a zero-wait AHB-Lite register slave.
 */
// Summary of operation
// - With search at start selected, every run command searches before normal running.
// - Release current threshold is a percentage of drive rated current, 0 to 200.
// - Release current default is 120 for V/f and 100 for open loop vector.
// - Search ramps frequency down; decel time spans maximum to minimum frequency.
// - Output voltage gain during search is the programmed 10 to 100 percent.
// - A search waits the delay time first so an output contactor can close.
// - Injected current is factor times motor rated current, clamped to drive rating.
// - Estimated motor speed is scaled by the detected speed gain, 1.00 to 1.20.
// - Restart direction comes from the reference, or from detected rotation when bidirectional.
// - During estimation, current is compared against the restart current level.
// - Estimation restarts only after current stays over that level for detect time.
// - Restarts are counted; exceeding the limit raises the retry fault and stops.
// - Method select chooses current detection (0) or speed estimation (1).
// - Successive restart attempts are separated by the restart wait time.
// - Frequency keeps falling while current exceeds release level; below it, speed is found.
// - Run-command searches wait the longer of minimum baseblock and delay time.
package search_pkg;

	// Register byte offsets
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_RELEASE = 8'h04;
	localparam logic [7:0] A_DECEL   = 8'h08;
	localparam logic [7:0] A_VGAIN   = 8'h0c;
	localparam logic [7:0] A_DELAY   = 8'h10;
	localparam logic [7:0] A_INJ     = 8'h14;
	localparam logic [7:0] A_SPDGAIN = 8'h18;
	localparam logic [7:0] A_RSTLVL  = 8'h1c;
	localparam logic [7:0] A_RSTDET  = 8'h20;
	localparam logic [7:0] A_RSTLIM  = 8'h24;
	localparam logic [7:0] A_RSTWAIT = 8'h28;
	localparam logic [7:0] A_STATUS  = 8'h2c;
	localparam logic [7:0] A_MASK    = 8'h30;
	localparam logic [7:0] A_STATE   = 8'h34;

	// Control register fields
	localparam int B_AT_START = 0;
	localparam int B_METHOD   = 1;
	localparam int B_BIDIR    = 2;
	localparam int B_MOTOR2   = 3;
	localparam int CM_LSB     = 4;
	localparam logic [1:0] CM_VF  = 2'h0;
	localparam logic [1:0] CM_OLV = 2'h2;

	// Status and mask bits
	localparam int S_DONE    = 0;
	localparam int S_FAULT   = 1;
	localparam int S_RESTART = 2;

	// Setting ranges and reset values
	localparam logic [7:0] PCT_MAX     = 8'hc8;
	localparam logic [7:0] REL_DEF_VF  = 8'h78;
	localparam logic [7:0] REL_DEF_OLV = 8'h64;
	localparam logic [6:0] DECEL_MIN   = 7'h01;
	localparam logic [6:0] DECEL_MAX   = 7'h64;
	localparam logic [6:0] DECEL_DEF   = 7'h14;
	localparam logic [6:0] VGAIN_MIN   = 7'h0a;
	localparam logic [6:0] VGAIN_MAX   = 7'h64;
	localparam logic [6:0] VGAIN_DEF   = 7'h64;
	localparam logic [9:0] DELAY_MAX   = 10'h3e8;
	localparam logic [9:0] DELAY_DEF   = 10'h002;
	localparam logic [4:0] INJ_MAX     = 5'h14;
	localparam logic [4:0] INJ_DEF     = 5'h05;
	localparam logic [6:0] SPD_MIN     = 7'h64;
	localparam logic [6:0] SPD_MAX     = 7'h78;
	localparam logic [6:0] SPD_DEF     = 7'h69;
	localparam logic [7:0] RSTLVL_DEF  = 8'h96;
	localparam logic [6:0] RSTDET_MAX  = 7'h64;
	localparam logic [6:0] RSTDET_DEF  = 7'h0a;
	localparam logic [3:0] RSTLIM_MAX  = 4'ha;
	localparam logic [3:0] RSTLIM_DEF  = 4'h3;
	localparam logic [8:0] RSTWAIT_MAX = 9'h12c;
	localparam logic [8:0] RSTWAIT_DEF = 9'h005;
	localparam logic [15:0] FACTOR_DIV = 16'h000a;
	localparam logic [15:0] GAIN_DIV   = 16'h0064;

	// Timing: one tick is 10 ms; 0.1 s settings are ten ticks
	localparam int TICK_PERIOD_NS = 32'h0098_9680;
	localparam int CLK_PERIOD_NS  = 32'h0000_0008;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [15:0] TENTH_TICKS = 16'h000a;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_DELAY  = 3'h1,
		ST_INJECT = 3'h2,
		ST_SEARCH = 3'h3,
		ST_RUN    = 3'h4,
		ST_WAIT   = 3'h5,
		ST_FAULT  = 3'h6
	} state_t;

endpackage : search_pkg

// file: hw/search_tick.sv
/*
 * Free-running tick generator: one-cycle pulse every CYCLES clocks.
 * Assumes a synchronous active-high reset.
 */
`timescale 1ns/1ps
module search_tick
	import search_pkg::*;
#(
	parameter int CYCLES = TICK_CYCLES
) (
	input  wire logic clock,
	input  wire logic reset,
	output logic      tick
);
	localparam int CW = $clog2(CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] count;
		logic          tick;
	} tick_st_t;

	tick_st_t s;
	tick_st_t next_s;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.count == CW'(CYCLES - 1)) begin
			next_s.count = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.count = s.count + CW'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

endmodule : search_tick

// file: hw/speed_search.sv
/*
 * Speed search sequencer for a coasting motor, with AHB-Lite register slave
 * and masked interrupt.
 * Assumes synchronous motor-side inputs; current in percent of drive rating.
 */
`timescale 1ns/1ps
module speed_search
	import search_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        run_cmd,
	input  wire logic        ext_search_max,
	input  wire logic        ext_search_ref,
	input  wire logic [8:0]  motor_current,
	input  wire logic [15:0] freq_ref,
	input  wire logic        ref_reverse,
	input  wire logic [15:0] max_output_frequency,
	input  wire logic [15:0] min_output_frequency,
	input  wire logic [9:0]  min_baseblock_time,
	input  wire logic [15:0] motor_rated_current,
	input  wire logic [15:0] motor2_rated_current,
	input  wire logic [15:0] drive_rated_current,
	input  wire logic [15:0] est_speed,
	input  wire logic        est_reverse,
	input  wire logic        est_valid,
	output logic      [15:0] out_freq,
	output logic             out_reverse,
	output logic      [6:0]  volt_gain,
	output logic      [15:0] inject_current,
	output logic             inject_en,
	output logic             searching,
	output logic             drive_run,
	output logic             search_retry_fault,
	output logic             irq
);
	typedef struct packed {
		state_t      state;
		logic        run_q;
		logic [5:0]  ctrl;
		logic [7:0]  release_cur;
		logic [6:0]  decel;
		logic [6:0]  vgain;
		logic [9:0]  delay;
		logic [4:0]  inj;
		logic [6:0]  spd_gain;
		logic [7:0]  rst_lvl;
		logic [6:0]  rst_det;
		logic [3:0]  rst_lim;
		logic [8:0]  rst_wait;
		logic [2:0]  status;
		logic [2:0]  mask;
		logic        irq;
		logic [15:0] timer;
		logic [6:0]  over_cnt;
		logic [3:0]  retries;
		logic [15:0] step;
		logic [15:0] out_freq;
		logic        out_reverse;
		logic [6:0]  volt_gain;
		logic [15:0] inject_current;
		logic        inject_en;
		logic        searching;
		logic        drive_run;
		logic        fault;
		logic        dp_write;
		logic [7:0]  dp_addr;
		logic [31:0] hrdata;
	} st_t;

	st_t         s;
	st_t         next_s;
	logic        tick;
	logic        start;
	logic        est_mode;
	logic [15:0] span;
	logic [15:0] decel_ticks;
	logic [15:0] step_calc;
	logic [15:0] wait_ticks;
	logic [15:0] rated;
	logic [20:0] inj_amp;
	logic [22:0] spd_prod;
	logic [15:0] spd_scaled;
	logic [2:0]  ev;
	logic [2:0]  clr;

	function automatic logic [15:0] clamp(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
		if (v < {16'h0000, lo}) begin
			return lo;
		end
		if (v > {16'h0000, hi}) begin
			return hi;
		end
		return v[15:0];
	endfunction : clamp

	search_tick #(
		.CYCLES (TICK_LEN)
	) u_tick (
		.clock (clock),
		.reset (reset),
		.tick  (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Derived quantities

	always_comb begin
		start = run_cmd && !s.run_q;
		est_mode = s.ctrl[B_METHOD];
		span = (max_output_frequency > min_output_frequency) ?
			max_output_frequency - min_output_frequency : 16'h0000;
		decel_ticks = 16'(s.decel) * TENTH_TICKS;
		step_calc = span / decel_ticks;
		if (step_calc == 16'h0000) begin
			step_calc = 16'h0001;
		end
		// Longer of baseblock and delay time
		wait_ticks = (min_baseblock_time > s.delay) ? 16'(min_baseblock_time) * TENTH_TICKS :
			16'(s.delay) * TENTH_TICKS;
		rated = s.ctrl[B_MOTOR2] ? motor2_rated_current : motor_rated_current;
		inj_amp = (21'(s.inj) * 21'(rated)) / 21'(FACTOR_DIV);
		spd_prod = (23'(est_speed) * 23'(s.spd_gain)) / 23'(GAIN_DIV);
		// Saturate rather than wrap on an absurd estimate
		spd_scaled = (|spd_prod[22:16]) ? 16'hffff : spd_prod[15:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s = s;
		ev = 3'h0;
		clr = 3'h0;
		next_s.run_q = run_cmd;

		// Bus data phase: registered address, zero wait
		if (s.dp_write) begin
			unique case (s.dp_addr)
				A_CTRL: begin
					next_s.ctrl = hwdata[5:0];
					// A change to V/f or open loop vector reloads its release-current default; other methods keep it
					if (hwdata[CM_LSB+1:CM_LSB] != s.ctrl[CM_LSB+1:CM_LSB]) begin
						if (hwdata[CM_LSB+1:CM_LSB] == CM_OLV) begin
							next_s.release_cur = REL_DEF_OLV;
						end else if (hwdata[CM_LSB+1:CM_LSB] == CM_VF) begin
							next_s.release_cur = REL_DEF_VF;
						end
					end
				end
				A_RELEASE: next_s.release_cur = 8'(clamp(hwdata, 16'h0000, 16'(PCT_MAX)));
				A_DECEL:   next_s.decel = 7'(clamp(hwdata, 16'(DECEL_MIN), 16'(DECEL_MAX)));
				A_VGAIN:   next_s.vgain = 7'(clamp(hwdata, 16'(VGAIN_MIN), 16'(VGAIN_MAX)));
				A_DELAY:   next_s.delay = 10'(clamp(hwdata, 16'h0000, 16'(DELAY_MAX)));
				A_INJ:     next_s.inj = 5'(clamp(hwdata, 16'h0000, 16'(INJ_MAX)));
				A_SPDGAIN: next_s.spd_gain = 7'(clamp(hwdata, 16'(SPD_MIN), 16'(SPD_MAX)));
				A_RSTLVL:  next_s.rst_lvl = 8'(clamp(hwdata, 16'h0000, 16'(PCT_MAX)));
				A_RSTDET:  next_s.rst_det = 7'(clamp(hwdata, 16'h0000, 16'(RSTDET_MAX)));
				A_RSTLIM:  next_s.rst_lim = 4'(clamp(hwdata, 16'h0000, 16'(RSTLIM_MAX)));
				A_RSTWAIT: next_s.rst_wait = 9'(clamp(hwdata, 16'h0000, 16'(RSTWAIT_MAX)));
				A_STATUS:  clr = hwdata[2:0];
				A_MASK:    next_s.mask = hwdata[2:0];
				default: ;
			endcase
		end

		// Sequencer
		if (s.timer != 16'h0000 && tick) begin
			next_s.timer = s.timer - 16'h0001;
		end
		if (!run_cmd && s.state != ST_IDLE) begin
			next_s.state = ST_IDLE;
			next_s.inject_en = 1'b0;
		end else begin
			unique case (s.state)
				ST_IDLE: begin
					if (start) begin
						next_s.step = step_calc;
						next_s.out_reverse = ref_reverse;
						if (s.ctrl[B_AT_START] || ext_search_max || ext_search_ref) begin
							next_s.retries = 4'h0;
							next_s.over_cnt = 7'h00;
							next_s.timer = wait_ticks;
							next_s.state = ST_DELAY;
							// At-start search ignores the external commands
							next_s.out_freq = (ext_search_ref && !ext_search_max && !s.ctrl[B_AT_START]) ?
								freq_ref : max_output_frequency;
						end else begin
							next_s.retries = 4'h0;
							next_s.out_freq = min_output_frequency;
							next_s.state = ST_RUN;
						end
					end
				end
				ST_DELAY: begin
					if (s.timer == 16'h0000) begin
						next_s.state = est_mode ? ST_INJECT : ST_SEARCH;
					end
				end
				ST_WAIT: begin
					if (s.timer == 16'h0000) begin
						next_s.over_cnt = 7'h00;
						next_s.state = ST_INJECT;
					end
				end
				ST_INJECT, ST_SEARCH: begin
					if (s.state == ST_INJECT) begin
						next_s.inject_en = 1'b1;
						next_s.inject_current = (inj_amp > {5'h00, drive_rated_current}) ?
							drive_rated_current : inj_amp[15:0];
						if (est_valid) begin
							next_s.out_freq = spd_scaled;
							next_s.out_reverse = s.ctrl[B_BIDIR] ? est_reverse : ref_reverse;
							next_s.inject_en = 1'b0;
							next_s.state = ST_SEARCH;
						end
					end else if (tick) begin
						if ({1'b0, motor_current} > {2'h0, s.release_cur}) begin
							next_s.out_freq = (s.out_freq > min_output_frequency + s.step) ?
								s.out_freq - s.step : min_output_frequency;
						end else begin
							next_s.retries = 4'h0;
							ev[S_DONE] = 1'b1;
							next_s.state = ST_RUN;
						end
					end
					// Overcurrent watch while estimating
					if (est_mode && tick) begin
						if ({1'b0, motor_current} > {2'h0, s.rst_lvl}) begin
							if (s.over_cnt + 7'h01 >= s.rst_det) begin
								next_s.retries = s.retries + 4'h1;
								next_s.inject_en = 1'b0;
								next_s.over_cnt = 7'h00;
								if (s.retries + 4'h1 > s.rst_lim) begin
									ev[S_FAULT] = 1'b1;
									next_s.state = ST_FAULT;
								end else begin
									ev[S_RESTART] = 1'b1;
									next_s.timer = 16'(s.rst_wait) * TENTH_TICKS;
									next_s.state = ST_WAIT;
								end
							end else begin
								next_s.over_cnt = s.over_cnt + 7'h01;
							end
						end else begin
							next_s.over_cnt = 7'h00;
						end
					end
				end
				ST_RUN: begin
					if (tick) begin
						next_s.out_reverse = ref_reverse;
						if (s.out_freq + s.step < freq_ref) begin
							next_s.out_freq = s.out_freq + s.step;
						end else if (s.out_freq > freq_ref + s.step) begin
							next_s.out_freq = s.out_freq - s.step;
						end else begin
							next_s.out_freq = freq_ref;
						end
					end
				end
				ST_FAULT: ;
				default: next_s.state = ST_IDLE;
			endcase
		end

		next_s.searching = next_s.state inside {ST_DELAY, ST_INJECT, ST_SEARCH, ST_WAIT};
		next_s.volt_gain = (next_s.state inside {ST_INJECT, ST_SEARCH}) ? s.vgain : VGAIN_MAX;
		next_s.drive_run = next_s.state == ST_RUN;
		next_s.fault = next_s.state == ST_FAULT;
		if (!next_s.inject_en) begin
			next_s.inject_current = 16'h0000;
		end

		// Set wins over a write-one clear in the same cycle
		next_s.status = (s.status & ~clr) | ev;
		next_s.irq = |(next_s.status & s.mask);

		// Address phase: read data prepared for the data phase
		next_s.dp_write = hsel && htrans[1] && hready && hwrite;
		next_s.dp_addr = haddr[7:0];
		next_s.hrdata = 32'h0000_0000;
		if (hsel && htrans[1] && hready && !hwrite) begin
			unique case (haddr[7:0])
				A_CTRL:    next_s.hrdata = 32'(next_s.ctrl);
				A_RELEASE: next_s.hrdata = 32'(next_s.release_cur);
				A_DECEL:   next_s.hrdata = 32'(next_s.decel);
				A_VGAIN:   next_s.hrdata = 32'(next_s.vgain);
				A_DELAY:   next_s.hrdata = 32'(next_s.delay);
				A_INJ:     next_s.hrdata = 32'(next_s.inj);
				A_SPDGAIN: next_s.hrdata = 32'(next_s.spd_gain);
				A_RSTLVL:  next_s.hrdata = 32'(next_s.rst_lvl);
				A_RSTDET:  next_s.hrdata = 32'(next_s.rst_det);
				A_RSTLIM:  next_s.hrdata = 32'(next_s.rst_lim);
				A_RSTWAIT: next_s.hrdata = 32'(next_s.rst_wait);
				A_STATUS:  next_s.hrdata = 32'(next_s.status);
				A_MASK:    next_s.hrdata = 32'(next_s.mask);
				A_STATE:   next_s.hrdata = {21'h000000, next_s.retries, 4'h0, s.state};
				default:   next_s.hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s <= '0;
			s.state <= ST_IDLE;
			s.release_cur <= REL_DEF_VF;
			s.decel <= DECEL_DEF;
			s.vgain <= VGAIN_DEF;
			s.delay <= DELAY_DEF;
			s.inj <= INJ_DEF;
			s.spd_gain <= SPD_DEF;
			s.rst_lvl <= RSTLVL_DEF;
			s.rst_det <= RSTDET_DEF;
			s.rst_lim <= RSTLIM_DEF;
			s.rst_wait <= RSTWAIT_DEF;
			s.step <= 16'h0001;
			s.volt_gain <= VGAIN_MAX;
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		hrdata = s.hrdata;
		hreadyout = 1'b1;
		hresp = 1'b0;
		out_freq = s.out_freq;
		out_reverse = s.out_reverse;
		volt_gain = s.volt_gain;
		inject_current = s.inject_current;
		inject_en = s.inject_en;
		searching = s.searching;
		drive_run = s.drive_run;
		search_retry_fault = s.fault;
		irq = s.irq;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	AST_START_SEARCH: assert property (
		(s.state == ST_IDLE && run_cmd && !s.run_q && s.ctrl[B_AT_START]) |=> s.state == ST_DELAY
	) else $error("run with search at start did not enter delay");

	AST_VGAIN: assert property (
		(s.state == ST_SEARCH && $past(s.state) == ST_SEARCH) |-> volt_gain == $past(s.vgain)
	) else $error("search voltage gain not applied");

	AST_DELAY_HOLD: assert property (
		(s.state == ST_DELAY && s.timer != 16'h0000 && run_cmd) |=> s.state == ST_DELAY
	) else $error("search left delay before time");

	AST_INJ_CLAMP: assert property (
		inject_en |-> inject_current <= $past(drive_rated_current)
	) else $error("injection current above drive rating");

	AST_RAMP_STEP: assert property (
		(s.state == ST_SEARCH && tick && run_cmd && ({1'b0, motor_current} > {2'h0, s.release_cur})
			&& s.out_freq > min_output_frequency + s.step) |=> s.out_freq == $past(s.out_freq) - $past(s.step)
	) else $error("search ramp step wrong");

	AST_FOUND: assert property (
		(s.state == ST_SEARCH && tick && run_cmd && !est_mode
			&& ({1'b0, motor_current} <= {2'h0, s.release_cur})) |=> s.state == ST_RUN ##1 drive_run
	) else $error("speed not declared found");

	AST_RESTART_TIME: assert property (
		$rose(s.state == ST_WAIT) |-> $past(s.over_cnt) + 7'h01 >= $past(s.rst_det)
	) else $error("restart before detect time");

	AST_FAULT_LIMIT: assert property (
		s.state == ST_FAULT |-> s.retries > s.rst_lim
	) else $error("retry fault below limit");

	AST_WAIT_HOLD: assert property (
		(s.state == ST_WAIT && s.timer != 16'h0000 && run_cmd) |=> s.state == ST_WAIT
	) else $error("restart wait cut short");

	AST_COUNT_CLEAR: assert property (
		s.state == ST_RUN |-> s.retries == 4'h0
	) else $error("retry count not cleared");

	COV_FOUND: cover property (s.state == ST_SEARCH ##1 s.state == ST_RUN);
	COV_RETRY: cover property (s.state == ST_WAIT ##1 s.state == ST_INJECT);
	COV_FAULT: cover property (s.state == ST_FAULT && search_retry_fault);

endmodule : speed_search

// file: dv/motor_model.sv
/*
 * Coasting induction motor seen through the output stage and current feedback.
 * Assumes the sequencer's registered outputs on the same clock.
 */
`timescale 1ns/1ps
module motor_model #(
	parameter logic [15:0] COAST = 16'h03e8
) (
	input  wire logic        clock,
	input  wire logic        hot,
	input  wire logic [15:0] out_freq,
	input  wire logic        inject_en,
	output logic      [8:0]  motor_current,
	output logic      [15:0] est_speed,
	output logic             est_reverse,
	output logic             est_valid
);
	logic [1:0] inj_cnt = 2'h0;

	// Output above shaft speed draws heavy current; hot forces a stalled load
	assign motor_current = hot ? 9'h0b4 : ((out_freq > COAST) ? 9'h096 : 9'h032);
	// Estimate is garbage until settled, so never a stale value
	assign est_speed = est_valid ? COAST : ~COAST;
	assign est_reverse = est_valid ? 1'b1 : inj_cnt[0];
	assign est_valid = (inj_cnt == 2'h3);

	always @(posedge clock) begin
		if (!inject_en)
			inj_cnt <= 2'h0;
		else if (inj_cnt != 2'h3)
			inj_cnt <= inj_cnt + 2'h1;
	end
endmodule : motor_model

// file: dv/tb_speed_search.sv
/*
 * Self-checking bench of the speed search sequencer over AHB-Lite.
 * Assumes the motor model as far side and a short tick for simulation.
 */
`timescale 1ns/1ps
module tb_speed_search;
	import search_pkg::*;
	localparam int TL = 16;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        run_cmd = 1'b0;
	logic        hot = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	logic [1:0]  htrans = 2'h0;
	logic [9:0]  bb = 10'h001;
	logic        ext_max = 1'b0;
	logic        ext_ref = 1'b0;
	logic        ref_rev = 1'b0;
	logic [15:0] fref = 16'h035c;
	logic [15:0] drv = 16'h0096;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, out_reverse, inject_en, searching, drive_run, search_retry_fault, irq;
	logic        est_reverse, est_valid;
	logic [8:0]  motor_current;
	logic [15:0] out_freq, inject_current, est_speed;
	logic [6:0]  volt_gain;
	int          error_cnt = 0;
	int          checks = 0;
	int          i, n;
	logic [7:0]  da [8] = '{A_RELEASE, A_DECEL, A_DELAY, A_SPDGAIN, A_RSTLVL, A_RSTDET, A_RSTLIM, A_RSTWAIT};
	logic [31:0] dv [8] = '{32'h78, 32'h14, 32'h2, 32'h69, 32'h96, 32'ha, 32'h3, 32'h5};

	always #4 clock = ~clock;

	speed_search #(.TICK_LEN(TL)) speed_search_inst (.clock(clock), .reset(reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .run_cmd(run_cmd), .ext_search_max(ext_max),
		.ext_search_ref(ext_ref), .motor_current(motor_current), .freq_ref(fref), .ref_reverse(ref_rev),
		.max_output_frequency(16'h07d0), .min_output_frequency(16'h0064), .min_baseblock_time(bb),
		.motor_rated_current(16'h0064), .motor2_rated_current(16'h0032), .drive_rated_current(drv),
		.est_speed(est_speed), .est_reverse(est_reverse), .est_valid(est_valid), .out_freq(out_freq),
		.out_reverse(out_reverse), .volt_gain(volt_gain), .inject_current(inject_current),
		.inject_en(inject_en), .searching(searching), .drive_run(drive_run),
		.search_retry_fault(search_retry_fault), .irq(irq));

	motor_model motor_model_inst (.clock(clock), .hot(hot), .out_freq(out_freq), .inject_en(inject_en),
		.motor_current(motor_current), .est_speed(est_speed), .est_reverse(est_reverse), .est_valid(est_valid));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	// Address phase held until hready, then data phase held until hready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(name, rd, e);
	endtask : rdchk

	// Bounded wait; a miss shows up in the compare that follows
	task automatic till(ref logic s, input logic v);
		for (n = 0; n < 4000 && s !== v; n++) begin
			@(posedge clock);
			#1;
		end
	endtask : till

	task automatic give_verdict;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		for (i = 0; i < 8; i++)
			rdchk("default", da[i], dv[i]);
		rdchk("unmapped", 8'h40, 32'h0);
		wr(A_RELEASE, 32'hff);
		rdchk("release clamp", A_RELEASE, 32'hc8);
		wr(A_CTRL, 32'h20);
		rdchk("olv release", A_RELEASE, 32'h64);
		wr(A_CTRL, 32'h00);
		rdchk("vf release", A_RELEASE, 32'h78);
		$display("test registers done");

		wr(A_CTRL, 32'h1);
		wr(A_DECEL, 32'h1);
		wr(A_VGAIN, 32'h32);
		run_cmd <= 1'b1;
		repeat (280) @(posedge clock);
		#1;
		chk("delay gain", {25'h0, volt_gain}, 32'h64);
		chk("delay searching", {31'h0, searching}, 32'h1);
		for (n = 0; n < 200 && volt_gain !== 7'h32; n++) begin
			@(posedge clock);
			#1;
		end
		chk("search gain", {25'h0, volt_gain}, 32'h32);
		chk("start freq", {16'h0, out_freq}, 32'h7d0);
		till(drive_run, 1'b1);
		chk("found freq", {16'h0, out_freq}, 32'h35c);
		chk("search over", {31'h0, searching}, 32'h0);
		chk("masked irq", {31'h0, irq}, 32'h0);
		wr(A_MASK, 32'h7);
		// Mask lands at the data-phase edge; irq is registered one edge later
		@(posedge clock);
		#1;
		chk("irq", {31'h0, irq}, 32'h1);
		wr(A_STATUS, 32'h1);
		rdchk("status clear", A_STATUS, 32'h0);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		run_cmd <= 1'b0;
		$display("test current detection done");

		wr(A_CTRL, 32'h7);
		wr(A_DELAY, 32'h0);
		wr(A_INJ, 32'h14);
		bb <= 10'h000;
		run_cmd <= 1'b1;
		till(inject_en, 1'b1);
		chk("inject clamp", {16'h0, inject_current}, 32'h96);
		till(inject_en, 1'b0);
		chk("est freq", {16'h0, out_freq}, 32'h41a);
		chk("est dir", {31'h0, out_reverse}, 32'h1);
		till(drive_run, 1'b1);
		chk("est run", {16'h0, out_freq}, 32'h35c);
		run_cmd <= 1'b0;
		$display("test speed estimation done");

		hot <= 1'b1;
		wr(A_RSTDET, 32'h1);
		wr(A_RSTWAIT, 32'h1);
		for (i = 0; i < 2; i++) begin
			wr(A_RSTLIM, i);
			run_cmd <= 1'b1;
			till(search_retry_fault, 1'b1);
			chk("fault", {31'h0, search_retry_fault}, 32'h1);
			chk("fault stop", {31'h0, drive_run}, 32'h0);
			rdchk("retries", A_STATE, ((i + 1) << 7) | 32'h6);
			run_cmd <= 1'b0;
			repeat (3) @(posedge clock);
		end
		$display("test retry limit done");

		// External requests without search at start; both inputs high picks maximum
		wr(A_CTRL, 32'h0);
		fref <= 16'h0320;
		ref_rev <= 1'b1;
		ext_ref <= 1'b1;
		for (i = 0; i < 2; i++) begin
			ext_max <= i[0];
			run_cmd <= 1'b1;
			till(searching, 1'b1);
			chk("ext start", {16'h0, out_freq}, (i != 0) ? 32'h7d0 : 32'h320);
			chk("ref dir", {31'h0, out_reverse}, 32'h1);
			run_cmd <= 1'b0;
			till(searching, 1'b0);
		end
		$display("test external search done");
		give_verdict();
	end

	initial begin
		#160000;
		error_cnt++;
		give_verdict();
	end
endmodule : tb_speed_search
